// [design/iss_slave.sv]
// two-wire bus slave with status register and ahb-lite register access
`default_nettype none
module iss_slave (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic timeout_event,
    output logic irq,
    output logic wake
);
    iss_pkg::iss_regs_t s;
    iss_pkg::iss_regs_t next_s;

    logic active;
    logic scl_s;
    logic scl_p;
    logic sda_s;
    logic sda_p;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic data_wr;
    logic data_rd;
    logic addr_hit;

    // read view of a register, used by the ahb read path
    function automatic logic [7:0] reg_view(
        input iss_pkg::iss_regs_t r,
        input logic [7:0] off
    );
        logic [7:0] v;
        v = 8'h00;
        unique case (off)
            iss_pkg::OFF_CTRL: v = {r.mode, 3'b000, r.en, 1'b0};
            iss_pkg::OFF_STAT: v = {r.byte_done, r.addr_match, r.busy,
                r.dir, r.ack_send, r.rw, r.wake_en, r.ack_rcv};
            iss_pkg::OFF_ADDR: v = r.own;
            iss_pkg::OFF_DATA: v = r.data;
            iss_pkg::OFF_TOUT: v = {1'b0, r.tout_flag, 5'b00000, r.irq_en};
            default: v = 8'h00;
        endcase
        return v;
    endfunction : reg_view

    // sampled pin levels and bus conditions
    assign scl_s = s.scl_sy[1];
    assign scl_p = s.scl_sy[2];
    assign sda_s = s.sda_sy[1];
    assign sda_p = s.sda_sy[2];
    assign rise = scl_s && !scl_p;
    assign fall = !scl_s && scl_p;
    assign start = scl_s && scl_p && sda_p && !sda_s; // [R3]
    assign stop = scl_s && scl_p && !sda_p && sda_s;
    assign active = (s.mode == iss_pkg::MODE_SLAVE) && s.en; // [R19]
    assign addr_hit = (s.shreg[6:0] == s.own[7:1]); // [R20]
    // software service of the shared data register
    assign data_wr = s.dp_wr && (s.dp_addr == iss_pkg::OFF_DATA);
    assign data_rd = s.dp_rd && !s.rd_ready &&
        (s.dp_addr == iss_pkg::OFF_DATA);

    // next state of bus slave, registers and protocol engine
    always_comb begin
        next_s = s;
        next_s.scl_sy = {s.scl_sy[1:0], scl_in};
        next_s.sda_sy = {s.sda_sy[1:0], sda_in};
        next_s.en_prev = s.en;

        // ahb data phase: writes land now, reads wait one cycle
        if (s.dp_rd && !s.rd_ready) begin
            next_s.rdata = {24'h00_0000, reg_view(s, s.dp_addr)};
            next_s.rd_ready = 1'b1;
        end
        if (s.dp_wr) begin
            unique case (s.dp_addr)
                iss_pkg::OFF_CTRL: begin
                    next_s.mode = hwdata[7:5];
                    next_s.en = hwdata[iss_pkg::CTRL_EN];
                end
                iss_pkg::OFF_STAT: begin
                    next_s.dir = hwdata[iss_pkg::STAT_DIR]; // [R5]
                    next_s.ack_send = hwdata[iss_pkg::STAT_ACKS];
                    next_s.wake_en = hwdata[iss_pkg::STAT_WAKE];
                end
                iss_pkg::OFF_ADDR: next_s.own = hwdata[7:0];
                iss_pkg::OFF_DATA: next_s.data = hwdata[7:0];
                iss_pkg::OFF_TOUT: begin
                    if (!hwdata[iss_pkg::TOUT_FLAG]) begin
                        next_s.tout_flag = 1'b0;
                    end
                    next_s.irq_en = hwdata[iss_pkg::TOUT_IRQEN];
                end
                default: begin
                end
            endcase
        end
        // new address phase once the bus is ready
        if (hready) begin
            next_s.dp_wr = 1'b0;
            next_s.dp_rd = 1'b0;
            next_s.rd_ready = 1'b0;
            if (hsel && htrans[1] && hsize == iss_pkg::SIZE_WORD) begin
                next_s.dp_wr = hwrite;
                next_s.dp_rd = !hwrite;
                next_s.dp_addr = haddr[7:0];
            end
        end

        // servicing the data register drops the held request
        if (data_wr || data_rd) begin
            next_s.irq_pend = 1'b0; // [R22]
        end

        // enable rising in slave mode restores the flags
        if (s.en && !s.en_prev && s.mode == iss_pkg::MODE_SLAVE) begin
            next_s.byte_done = iss_pkg::STAT_RESET[7]; // [R21]
            next_s.addr_match = 1'b0;
            next_s.busy = 1'b0;
            next_s.rw = 1'b0;
            next_s.ack_rcv = iss_pkg::STAT_RESET[0];
            next_s.st = iss_pkg::ISS_IDLE;
        end else if (!active) begin
            next_s.st = iss_pkg::ISS_IDLE; // [R19]
            next_s.sda_drv = 1'b0;
            next_s.scl_hold = 1'b0;
        end else if (start) begin
            next_s.busy = 1'b1; // [R4]
            next_s.st = iss_pkg::ISS_ADDR;
            next_s.cnt = 4'h0;
            next_s.byte_done = 1'b0;
            next_s.addr_match = 1'b0;
            next_s.sda_drv = 1'b0;
            next_s.scl_hold = 1'b0;
        end else if (stop) begin
            next_s.busy = 1'b0; // [R4]
            next_s.st = iss_pkg::ISS_IDLE;
            next_s.sda_drv = 1'b0;
            next_s.scl_hold = 1'b0;
        end else begin
            unique case (s.st)
                iss_pkg::ISS_IDLE: begin
                end
                // address bits msb first, then the read/write bit
                iss_pkg::ISS_ADDR: begin
                    if (rise) begin
                        next_s.shreg = {s.shreg[6:0], sda_s}; // [R12]
                        next_s.cnt = s.cnt + 4'h1;
                        if (s.cnt == iss_pkg::LAST_BIT) begin
                            if (addr_hit) begin
                                next_s.addr_match = 1'b1; // [R2]
                                next_s.rw = sda_s; // [R7] [R8]
                                next_s.irq_pend = 1'b1; // [R12] [R18]
                                next_s.ackbit = 1'b0; // [R13]
                                next_s.cnt = 4'h0;
                                next_s.st = iss_pkg::ISS_ACK;
                                if (s.wake_en) begin
                                    next_s.wake = 1'b1; // [R9]
                                end
                            end else begin
                                next_s.addr_match = 1'b0; // [R2]
                                next_s.st = iss_pkg::ISS_WSTOP;
                            end
                        end
                    end
                end
                // ninth clock: drive ack, then hold clock low
                iss_pkg::ISS_ACK: begin
                    if (fall) begin
                        if (s.cnt == 4'h0) begin
                            next_s.sda_drv = !s.ackbit; // [R6] [R13] [R16]
                            next_s.cnt = 4'h1;
                        end else begin
                            next_s.sda_drv = 1'b0;
                            next_s.byte_done = 1'b1; // [R1]
                            next_s.irq_pend = 1'b1; // [R18]
                            next_s.scl_hold = 1'b1; // [R14]
                            next_s.st = iss_pkg::ISS_HOLD;
                        end
                    end
                end
                // clock stretched until software services the data
                iss_pkg::ISS_HOLD: begin
                    if (s.dir && data_wr) begin
                        next_s.shreg = hwdata[7:0]; // [R15]
                        next_s.sda_drv = !hwdata[7];
                        next_s.scl_hold = 1'b0; // [R14]
                        next_s.byte_done = 1'b0; // [R1]
                        next_s.cnt = 4'h0;
                        next_s.st = iss_pkg::ISS_TX; // [R5]
                    end else if (!s.dir && data_rd) begin
                        next_s.scl_hold = 1'b0; // [R14]
                        next_s.byte_done = 1'b0; // [R1]
                        next_s.cnt = 4'h0;
                        next_s.st = iss_pkg::ISS_RX; // [R5]
                    end
                end
                // shift out msb first, new bit after each falling edge
                iss_pkg::ISS_TX: begin
                    if (rise) begin
                        next_s.cnt = s.cnt + 4'h1;
                    end else if (fall) begin
                        if (s.cnt == iss_pkg::BYTE_BITS) begin
                            next_s.sda_drv = 1'b0;
                            next_s.st = iss_pkg::ISS_TACK;
                        end else begin
                            next_s.shreg = {s.shreg[6:0], 1'b0}; // [R15]
                            next_s.sda_drv = !s.shreg[6];
                        end
                    end
                end
                // ninth clock as sender: sample the master's ack
                iss_pkg::ISS_TACK: begin
                    if (rise) begin
                        next_s.ack_rcv = sda_s; // [R10]
                    end else if (fall) begin
                        next_s.byte_done = 1'b1; // [R1]
                        next_s.irq_pend = 1'b1; // [R18]
                        if (s.ack_rcv) begin
                            next_s.st = iss_pkg::ISS_WSTOP; // [R11]
                        end else begin
                            next_s.scl_hold = 1'b1; // [R11] [R14]
                            next_s.st = iss_pkg::ISS_HOLD;
                        end
                    end
                end
                // shift in msb first, byte lands in the data register
                iss_pkg::ISS_RX: begin
                    if (rise) begin
                        next_s.shreg = {s.shreg[6:0], sda_s};
                        next_s.cnt = s.cnt + 4'h1;
                        if (s.cnt == iss_pkg::LAST_BIT) begin
                            next_s.data = {s.shreg[6:0], sda_s}; // [R15]
                            next_s.ackbit = s.ack_send; // [R6]
                            next_s.cnt = 4'h0;
                            next_s.st = iss_pkg::ISS_ACK;
                        end
                    end
                end
                // lines released, waiting for stop or a new start
                iss_pkg::ISS_WSTOP: begin
                end
            endcase
        end

        // wake drops in the same cycle as its enable, never lags it
        if (!next_s.wake_en) begin
            next_s.wake = 1'b0; // [R9]
        end
        // timeout source sets its flag last so the set wins
        if (timeout_event) begin
            next_s.tout_flag = 1'b1; // [R18]
        end
    end

    // state register with synchronous reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s <= '0;
            s.mode <= iss_pkg::MODE_RESET;
            s.byte_done <= iss_pkg::STAT_RESET[7];
            s.ack_rcv <= iss_pkg::STAT_RESET[0];
            s.own <= iss_pkg::ADDR_RESET;
            s.st <= iss_pkg::ISS_IDLE;
            s.scl_sy <= 3'b111;
            s.sda_sy <= 3'b111;
        end else begin
            s <= next_s;
        end
    end

    // pins drive low only, enables come from flip-flops
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe_n = !s.scl_hold;
    assign sda_oe_n = !s.sda_drv;
    assign hrdata = s.rdata;
    assign hresp = 1'b0;
    assign hreadyout = !(s.dp_rd && !s.rd_ready);
    assign irq = s.irq_en && (s.irq_pend || s.tout_flag); // [R18] [R22]
    assign wake = s.wake;

    // checks of the protocol engine
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    property p_busy_set;
        active && !(s.en && !s.en_prev) && start |=> s.busy;
    endproperty
    a_busy_set: assert property (p_busy_set) // [R4]
        else $error("busy flag not set after start");

    property p_busy_clr;
        active && !(s.en && !s.en_prev) && stop |=> !s.busy;
    endproperty
    a_busy_clr: assert property (p_busy_clr) // [R4]
        else $error("busy flag not cleared after stop");

    property p_done_low;
        (s.st == iss_pkg::ISS_TX || s.st == iss_pkg::ISS_RX) |-> !s.byte_done;
    endproperty
    a_done_low: assert property (p_done_low) // [R1]
        else $error("byte done high during transfer");

    property p_match;
        active && !start && !stop && !(s.en && !s.en_prev) &&
        s.st == iss_pkg::ISS_ADDR && rise && s.cnt == iss_pkg::LAST_BIT &&
        addr_hit |=> s.addr_match && s.irq_pend && s.rw == $past(sda_s) &&
        s.st == iss_pkg::ISS_ACK;
    endproperty
    a_match: assert property (p_match) // [R2]
        else $error("address match not flagged");

    property p_nomatch;
        active && !start && !stop && !(s.en && !s.en_prev) &&
        s.st == iss_pkg::ISS_ADDR && rise && s.cnt == iss_pkg::LAST_BIT &&
        !addr_hit |=> !s.addr_match && s.st == iss_pkg::ISS_WSTOP;
    endproperty
    a_nomatch: assert property (p_nomatch) // [R2]
        else $error("mismatched address accepted");

    property p_hold;
        s.st == iss_pkg::ISS_HOLD |-> !scl_oe_n;
    endproperty
    a_hold: assert property (p_hold) // [R14]
        else $error("clock not held while waiting for software");

    property p_ack_drive;
        s.st == iss_pkg::ISS_ACK && s.cnt == 4'h1 |-> sda_oe_n == s.ackbit;
    endproperty
    a_ack_drive: assert property (p_ack_drive) // [R6]
        else $error("ninth bit does not follow ack control");

    property p_tack_sample;
        active && !start && !stop && !(s.en && !s.en_prev) &&
        s.st == iss_pkg::ISS_TACK && rise |=> s.ack_rcv == $past(sda_s);
    endproperty
    a_tack_sample: assert property (p_tack_sample) // [R10]
        else $error("received ack not recorded");

    property p_nack_release;
        active && !start && !stop && !(s.en && !s.en_prev) &&
        s.st == iss_pkg::ISS_TACK && fall && s.ack_rcv |=>
        sda_oe_n && scl_oe_n && s.st == iss_pkg::ISS_WSTOP [*2];
    endproperty
    a_nack_release: assert property (p_nack_release) // [R11]
        else $error("lines not released after missing ack");

    property p_inactive;
        !active |=> s.st == iss_pkg::ISS_IDLE && sda_oe_n && scl_oe_n;
    endproperty
    a_inactive: assert property (p_inactive) // [R19]
        else $error("slave active outside slave mode");

    property p_tx_start;
        active && !start && !stop && !(s.en && !s.en_prev) &&
        s.st == iss_pkg::ISS_HOLD && s.dir && data_wr |=>
        s.st == iss_pkg::ISS_TX && sda_oe_n == $past(hwdata[7]) && scl_oe_n;
    endproperty
    a_tx_start: assert property (p_tx_start) // [R5]
        else $error("transmit did not start on data write");

    property p_wake;
        s.wake |-> s.wake_en;
    endproperty
    a_wake: assert property (p_wake) // [R9]
        else $error("wake raised without enable");

    c_match: cover property (s.st == iss_pkg::ISS_ADDR
        ##1 s.st == iss_pkg::ISS_ACK);
    c_tx_byte: cover property (s.st == iss_pkg::ISS_TACK
        ##1 s.st == iss_pkg::ISS_HOLD);
    c_rx_byte: cover property (s.st == iss_pkg::ISS_RX
        ##1 s.st == iss_pkg::ISS_ACK);
    c_nack: cover property (s.st == iss_pkg::ISS_TACK
        ##1 s.st == iss_pkg::ISS_WSTOP);
endmodule : iss_slave
`default_nettype wire

// [design/iss_pkg.sv]
// package of constants and types for the two-wire slave block
//
// What this block does
// (R1) byte done flag is low while a byte moves, high after the ninth clock
// (R2) address match flag follows equality of received and own address
// (R3) start is data falling while clock stays high
// (R4) bus busy sets on start and clears on stop
// (R5) direction bit one means transmit, zero means receive
// (R6) after eight received bits the ack control bit is driven on clock nine
// (R7) the bit after the seven address bits lands in the read/write flag
// (R8) read/write one means slave sends, zero means slave receives
// (R9) with wake enable set, an address match raises the wake output
// (R10) as sender, data line on clock nine goes into the ack received flag
// (R11) sender keeps sending while acked, releases data on a missing ack
// (R12) first seven bits after start, msb first, compared; match requests irq
// (R13) on address match a low ack is driven as ninth bit
// (R14) after a match clock is held low until data write or dummy read
// (R15) bytes are eight bits, msb first, through the shared data register
// (R16) the receiving party returns a low ack before the next byte
// (R17) only the master makes start and ends an unacked call with stop
// (R18) one irq shared by match, byte done and timeout, told apart by flags
// (R19) slave works only with mode field 110 and enable set
// (R20) own address is bits 7 to 1 of the address register, bit 0 inert
// (R21) enable rising in slave mode resets flags, keeps direction and ack control bits
// (R22) irq is a level held until the source is serviced
`default_nettype none
package iss_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_ADDR = 8'h08;
    localparam logic [7:0] OFF_DATA = 8'h0C;
    localparam logic [7:0] OFF_TOUT = 8'h10;
    // field positions
    localparam int CTRL_EN = 1;
    localparam int STAT_DIR = 4;
    localparam int STAT_ACKS = 3;
    localparam int STAT_WAKE = 1;
    localparam int TOUT_FLAG = 6;
    localparam int TOUT_IRQEN = 0;
    // values after reset and codes
    localparam logic [2:0] MODE_RESET = 3'h7;
    localparam logic [2:0] MODE_SLAVE = 3'h6;
    localparam logic [7:0] STAT_RESET = 8'h81;
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [2:0] SIZE_WORD = 3'h2;

    // protocol states, gray along address, ack, hold, transmit path
    typedef enum logic [2:0] {
        ISS_IDLE = 3'b000,
        ISS_ADDR = 3'b001,
        ISS_ACK = 3'b011,
        ISS_HOLD = 3'b010,
        ISS_TX = 3'b110,
        ISS_TACK = 3'b111,
        ISS_RX = 3'b101,
        ISS_WSTOP = 3'b100
    } iss_state_t;

    // all state of the block
    typedef struct packed {
        logic [2:0] mode;
        logic en;
        logic en_prev;
        logic byte_done;
        logic addr_match;
        logic busy;
        logic dir;
        logic ack_send;
        logic rw;
        logic wake_en;
        logic ack_rcv;
        logic [7:0] own;
        logic [7:0] data;
        logic [7:0] shreg;
        logic tout_flag;
        logic irq_en;
        logic irq_pend;
        logic wake;
        iss_state_t st;
        logic [3:0] cnt;
        logic ackbit;
        logic sda_drv;
        logic scl_hold;
        logic [2:0] scl_sy;
        logic [2:0] sda_sy;
        logic dp_wr;
        logic dp_rd;
        logic rd_ready;
        logic [7:0] dp_addr;
        logic [31:0] rdata;
    } iss_regs_t;
endpackage : iss_pkg
`default_nettype wire

// [tb/iss_master_model.sv]
// behavioural two-wire bus master that drives the far side of the slave
`default_nettype none
module iss_master_model (
    input wire logic scl,
    input wire logic sda,
    output logic scl_m,
    output logic sda_m
);
    timeunit 1ns;
    timeprecision 1ns;

    // both lines released while idle, so the pull-up holds them high
    initial begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end

    // one 400 ns bus clock; the rise waits while the slave stretches
    task automatic clk_bit(input logic b, output logic s);
        #150 sda_m = b;
        #50 scl_m = 1'b1;
        wait (scl === 1'b1);
        #100 s = sda;
        #100 scl_m = 1'b0;
    endtask : clk_bit

    // start from an idle bus: data falls while clock is high
    task automatic start_cond;
        #10; // step off the system clock edge so pins never race it
        sda_m = 1'b1;
        scl_m = 1'b1;
        #200 sda_m = 1'b0;
        #200 scl_m = 1'b0;
    endtask : start_cond

    // stop: data rises while clock is high
    task automatic stop_cond;
        #10;
        #150 sda_m = 1'b0;
        #50 scl_m = 1'b1;
        wait (scl === 1'b1);
        #100 sda_m = 1'b1;
        #200;
    endtask : stop_cond

    // eight bits msb first, then the slave's answer on the ninth clock
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        #10;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], s);
        end
        clk_bit(1'b1, ack);
        #200; // let the slave act on the ninth falling edge
    endtask : write_byte

    // eight bits read msb first, then the master's own ack or nack
    task automatic read_byte(input logic ack_out, output logic [7:0] d);
        logic s;
        #10;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, d[i]);
        end
        clk_bit(ack_out, s);
        #200; // let the slave act on the ninth falling edge
    endtask : read_byte
endmodule : iss_master_model
`default_nettype wire

// [tb/iss_slave_tb.sv]
// self-checking bench for the two-wire slave block
`default_nettype none
module iss_slave_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, rst_n, hsel, hwrite, timeout_event, ack;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, scl_out, scl_oe_n, sda_out, sda_oe_n;
    logic irq, wake, scl_m, sda_m;
    logic [7:0] b;
    wire logic hready, scl, sda;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;

    // open-drain lines with pull-up; the bus hready is the slave's
    assign scl = scl_m & (scl_oe_n | scl_out);
    assign sda = sda_m & (sda_oe_n | sda_out);
    assign hready = hreadyout;

    iss_slave uut (.clock(clock), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl),
        .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .timeout_event(timeout_event), .irq(irq), .wake(wake));
    iss_master_model mst (.scl(scl), .sda(sda), .scl_m(scl_m),
        .sda_m(sda_m));

    // system clock, 50 ns period
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one single ahb-lite transfer; hready and read data taken at the edge
    task automatic ahb(input logic [7:0] a, input logic w,
        input logic [31:0] wd, output logic [31:0] rdat);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        hsize <= iss_pkg::SIZE_WORD;
        do @(posedge clock); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hready !== 1'b1);
        rdat = hrdata;
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] x;
        ahb(a, 1'b1, {24'h00_0000, d}, x);
    endtask : wr

    // read a register and compare the masked low byte, upper bits zero
    task automatic rdc(input logic [7:0] a, input logic [7:0] m,
        input logic [7:0] e, input string what);
        ahb(a, 1'b0, 32'h0000_0000, rd);
        check(what, rd & {24'hFF_FFFF, m}, {24'h00_0000, e});
    endtask : rdc

    task automatic t_reset;
        rdc(iss_pkg::OFF_CTRL, 8'hFF, 8'hE0, "ctrl");
        rdc(iss_pkg::OFF_STAT, 8'hFF, 8'h81, "status");
        rdc(iss_pkg::OFF_ADDR, 8'hFF, 8'h00, "addr");
        rdc(iss_pkg::OFF_TOUT, 8'hFF, 8'h00, "tout");
        rdc(8'h14, 8'hFF, 8'h00, "unmapped");
        check("hresp", hresp, 0);
    endtask : t_reset

    task automatic t_config;
        mst.start_cond;
        mst.write_byte(8'h54, ack);
        check("ack off", ack, 1);
        rdc(iss_pkg::OFF_STAT, 8'h60, 8'h00, "off flags");
        mst.stop_cond;
        wr(iss_pkg::OFF_CTRL, 8'hC2);
        rdc(iss_pkg::OFF_CTRL, 8'hFF, 8'hC2, "ctrl");
        wr(iss_pkg::OFF_ADDR, 8'h55);
        rdc(iss_pkg::OFF_ADDR, 8'hFF, 8'h55, "addr");
        wr(iss_pkg::OFF_TOUT, 8'h01);
        @(posedge clock);
        timeout_event <= 1'b1;
        @(posedge clock);
        timeout_event <= 1'b0;
        rdc(iss_pkg::OFF_TOUT, 8'hFF, 8'h41, "tout flag");
        check("irq tout", irq, 1);
        wr(iss_pkg::OFF_TOUT, 8'h01);
        repeat (2) @(posedge clock);
        check("irq clr", irq, 0);
    endtask : t_config

    task automatic t_master_write;
        wr(iss_pkg::OFF_STAT, 8'h02);
        mst.start_cond;
        rdc(iss_pkg::OFF_STAT, 8'h20, 8'h20, "busy");
        mst.write_byte(8'h54, ack);
        check("addr ack", ack, 0);
        rdc(iss_pkg::OFF_STAT, 8'hFF, 8'hE3, "match");
        check("irq match", irq, 1);
        check("wake", wake, 1);
        check("stretch", scl_oe_n, 0);
        rdc(iss_pkg::OFF_DATA, 8'h00, 8'h00, "dummy");
        repeat (3) @(posedge clock);
        check("irq svc", irq, 0);
        check("release", scl_oe_n, 1);
        mst.write_byte(8'hA5, ack);
        check("data ack", ack, 0);
        rdc(iss_pkg::OFF_STAT, 8'h80, 8'h80, "done");
        rdc(iss_pkg::OFF_DATA, 8'hFF, 8'hA5, "rx byte");
        wr(iss_pkg::OFF_STAT, 8'h08);
        repeat (2) @(posedge clock);
        check("wake off", wake, 0);
        mst.write_byte(8'h3C, ack);
        check("nack", ack, 1);
        rdc(iss_pkg::OFF_DATA, 8'hFF, 8'h3C, "rx byte");
        mst.stop_cond;
        rdc(iss_pkg::OFF_STAT, 8'h20, 8'h00, "free");
    endtask : t_master_write

    task automatic t_master_read;
        wr(iss_pkg::OFF_STAT, 8'h10);
        mst.start_cond;
        mst.write_byte(8'h55, ack);
        check("addr ack", ack, 0);
        rdc(iss_pkg::OFF_STAT, 8'h44, 8'h44, "rw");
        wr(iss_pkg::OFF_DATA, 8'h96);
        mst.read_byte(1'b0, b);
        check("tx byte", b, 8'h96);
        rdc(iss_pkg::OFF_STAT, 8'h81, 8'h80, "acked");
        wr(iss_pkg::OFF_DATA, 8'h5B);
        mst.read_byte(1'b1, b);
        check("tx byte", b, 8'h5B);
        rdc(iss_pkg::OFF_STAT, 8'h01, 8'h01, "nacked");
        check("sda free", sda_oe_n, 1);
        mst.stop_cond;
    endtask : t_master_read

    task automatic t_mismatch;
        mst.start_cond;
        mst.write_byte(8'h2A, ack);
        check("other addr", ack, 1);
        rdc(iss_pkg::OFF_STAT, 8'h40, 8'h00, "no match");
        mst.stop_cond;
        wr(iss_pkg::OFF_CTRL, 8'hC0);
        wr(iss_pkg::OFF_CTRL, 8'hC2);
        rdc(iss_pkg::OFF_STAT, 8'hFF, 8'h91, "reenable");
    endtask : t_mismatch

    // reset, then the scenarios in turn
    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        htrans = 2'h0;
        hsize = 3'h0;
        timeout_event = 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        t_reset;
        t_config;
        t_master_write;
        t_master_read;
        t_mismatch;
        tally_and_finish;
    end

    // watchdog against a hung handshake
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares++;
            tally_and_finish;
        end
    end
endmodule : iss_slave_tb
`default_nettype wire
